//--- hdl/smc_mode_decode.sv
// decodes one socket's mode byte into protocol and option flags
`default_nettype none
module smc_mode_decode
  import smc_pkg::*;
#(
  parameter int unsigned SOCK_ID = 0
) (
  smc_mode_if.decoder m
);
  logic [3:0] code;
  assign code = m.modeByte[SMC_PROTO_MSB:0];

  always_comb begin
    case (code)
      SMC_PROTO_TCP, SMC_PROTO_UDP, SMC_PROTO_RAWIP: begin
        m.liveProto = code;
      end
      SMC_PROTO_RAWFRAME, SMC_PROTO_PPPOE: begin
        m.liveProto = (SOCK_ID == 0) ? code : SMC_PROTO_CLOSED;
      end
      default: begin
        m.liveProto = SMC_PROTO_CLOSED;
      end
    endcase
  end

  // options follow the protocol the socket was opened with
  assign m.multicastEn = m.modeByte[SMC_BIT_MULTI] &&
    (m.activeProto == SMC_PROTO_UDP);
  assign m.frameFilterEn = m.modeByte[SMC_BIT_FILTER] &&
    (m.activeProto == SMC_PROTO_RAWFRAME);
  assign m.immediateAck = m.modeByte[SMC_BIT_OPTION] &&
    (m.activeProto == SMC_PROTO_TCP);
  assign m.igmpV1 = m.multicastEn && m.modeByte[SMC_BIT_OPTION];
endmodule
`default_nettype wire

//--- hdl/smc_mode_if.sv
// interface between the bank and one socket's mode decoder
`default_nettype none
interface smc_mode_if;
  logic [7:0] modeByte;
  logic [3:0] activeProto;
  logic [3:0] liveProto;
  logic multicastEn;
  logic frameFilterEn;
  logic immediateAck;
  logic igmpV1;
  modport bank (output modeByte, output activeProto, input liveProto,
    input multicastEn, input frameFilterEn, input immediateAck, input igmpV1);
  modport decoder (input modeByte, input activeProto, output liveProto,
    output multicastEn, output frameFilterEn, output immediateAck, output igmpV1);
endinterface
`default_nettype wire

//--- hdl/smc_pkg.sv
// constants and types for the socket mode configuration bank
`default_nettype none
package smc_pkg;
  localparam int unsigned SMC_NUM_SOCK = 8;
  localparam int unsigned SMC_IDX_W = 3;
  localparam logic [15:0] SMC_MODE_BASE = 16'h4000;
  localparam logic [15:0] SMC_SOCK_MASK = 16'h0700;
  localparam logic [15:0] SMC_CMD_OFS = 16'h0001;
  localparam int unsigned SMC_IDX_LSB = 8;
  localparam logic [7:0] SMC_CMD_OPEN = 8'h01;
  localparam logic [7:0] SMC_MODE_RESET = 8'h00;
  localparam logic [7:0] SMC_MODE_WR_MASK = 8'hEF;
  localparam int unsigned SMC_BIT_MULTI = 7;
  localparam int unsigned SMC_BIT_FILTER = 6;
  localparam int unsigned SMC_BIT_OPTION = 5;
  localparam int unsigned SMC_PROTO_MSB = 3;

  typedef enum logic [3:0] {
    SMC_PROTO_CLOSED = 4'h0,
    SMC_PROTO_TCP = 4'h1,
    SMC_PROTO_UDP = 4'h2,
    SMC_PROTO_RAWIP = 4'h3,
    SMC_PROTO_RAWFRAME = 4'h4,
    SMC_PROTO_PPPOE = 4'h5
  } smc_proto_t;
endpackage
`default_nettype wire

//--- hdl/smc_socket_mode_config.sv
// per-socket mode register bank with open-time protocol capture
`default_nettype none
// Function
// - eight 8-bit read/write mode registers at 0x4000 plus n*0x100, reset zero
// - low four bits pick closed, TCP, UDP or raw IP
// - raw frame and PPPoE codes honoured on socket 0 only
// - PPPoE socket may later be rewritten to another protocol
// - bit 7 enables multicast, only effective in UDP
// - raw frame mode: bit 6 set filters to own or broadcast frames
// - TCP mode: bit 5 set sends ACK immediately after each segment
// - UDP multicast: bit 5 clear IGMP version 2, set version 1
// - open command 0x01 initialises socket from current protocol field
module smc_socket_mode_config
  import smc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [15:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  output logic regHit,
  output logic [SMC_NUM_SOCK*4-1:0] sockProtocol,
  output logic [SMC_NUM_SOCK-1:0] sockOpenPulse,
  output logic [SMC_NUM_SOCK-1:0] sockMulticastEn,
  output logic [SMC_NUM_SOCK-1:0] sockFrameFilterEn,
  output logic [SMC_NUM_SOCK-1:0] sockImmediateAck,
  output logic [SMC_NUM_SOCK-1:0] sockIgmpV1
);
  typedef struct packed {
    logic [SMC_NUM_SOCK-1:0][7:0] mode;
    logic [SMC_NUM_SOCK-1:0][3:0] proto;
    logic [SMC_NUM_SOCK-1:0] openPulse;
    logic [SMC_NUM_SOCK-1:0] mcast;
    logic [SMC_NUM_SOCK-1:0] filt;
    logic [SMC_NUM_SOCK-1:0] ack;
    logic [SMC_NUM_SOCK-1:0] igmp;
    logic [7:0] rdData;
  } smc_state_t;

  smc_state_t st_r;
  smc_state_t st_nxt;

  logic [SMC_IDX_W-1:0] sel;
  logic modeHit;
  logic cmdHit;
  logic [SMC_NUM_SOCK-1:0][3:0] liveProto;
  logic [SMC_NUM_SOCK-1:0] decMcast;
  logic [SMC_NUM_SOCK-1:0] decFilt;
  logic [SMC_NUM_SOCK-1:0] decAck;
  logic [SMC_NUM_SOCK-1:0] decIgmp;

  // address decode: socket index sits in address bits 10:8
  assign sel = regAddr[SMC_IDX_LSB +: SMC_IDX_W];
  assign modeHit = ((regAddr & ~SMC_SOCK_MASK) == SMC_MODE_BASE);
  assign cmdHit = ((regAddr & ~SMC_SOCK_MASK) == (SMC_MODE_BASE | SMC_CMD_OFS));
  assign regHit = modeHit || cmdHit;

  smc_mode_if dec[SMC_NUM_SOCK] ();

  generate
    for (genvar i = 0; i < SMC_NUM_SOCK; i++) begin : g_sock
      assign dec[i].modeByte = st_r.mode[i];
      assign dec[i].activeProto = st_r.proto[i];
      assign liveProto[i] = dec[i].liveProto;
      assign decMcast[i] = dec[i].multicastEn;
      assign decFilt[i] = dec[i].frameFilterEn;
      assign decAck[i] = dec[i].immediateAck;
      assign decIgmp[i] = dec[i].igmpV1;
      smc_mode_decode #(
        .SOCK_ID(i)
      ) u_dec (
        .m(dec[i])
      );
    end
  endgenerate

  always_comb begin
    st_nxt = st_r;
    st_nxt.openPulse = '0;
    // mode is always writable, also after a PPPoE session is up
    if (regWrEn && modeHit) begin
      st_nxt.mode[sel] = regWrData & SMC_MODE_WR_MASK;
    end
    // open captures the protocol held right now in the mode register
    if (regWrEn && cmdHit && (regWrData == SMC_CMD_OPEN)) begin
      st_nxt.proto[sel] = liveProto[sel];
      st_nxt.openPulse[sel] = 1'b1;
    end
    // command location reads back zero, as the command self-clears
    if (regRdEn) begin
      st_nxt.rdData = modeHit ? st_r.mode[sel] : 8'h00;
    end
    st_nxt.mcast = decMcast;
    st_nxt.filt = decFilt;
    st_nxt.ack = decAck;
    st_nxt.igmp = decIgmp;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= '0;
      for (int i = 0; i < SMC_NUM_SOCK; i++) begin
        st_r.mode[i] <= SMC_MODE_RESET;
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regRdData = st_r.rdData;
  assign sockProtocol = st_r.proto;
  assign sockOpenPulse = st_r.openPulse;
  assign sockMulticastEn = st_r.mcast;
  assign sockFrameFilterEn = st_r.filt;
  assign sockImmediateAck = st_r.ack;
  assign sockIgmpV1 = st_r.igmp;
endmodule
`default_nettype wire

//--- test/smc_socket_mode_config_assertions.sv
// assertions for the socket mode bank
`default_nettype none
module smc_socket_mode_config_assertions
  import smc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [15:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic regHit,
  input wire logic [31:0] sockProtocol,
  input wire logic [7:0] sockOpenPulse,
  input wire logic [7:0] sockMulticastEn,
  input wire logic [7:0] sockFrameFilterEn,
  input wire logic [7:0] sockImmediateAck,
  input wire logic [7:0] sockIgmpV1
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_rd_bit4: assert property (regRdEn |=> !regRdData[4]) else $error("bit4 read set");
  a_unmapped_rd: assert property (regRdEn && !regHit |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_open_pulse: assert property (regWrEn && regAddr == 16'h4001 && regWrData == 8'h01
    |=> sockOpenPulse[0]) else $error("no open pulse");
  a_proto_s1: assert property (sockProtocol[7:4] < 4'h4) else $error("bad code");
  a_multi_udp: assert property (sockMulticastEn[1] |-> $past(sockProtocol[7:4]) == 4'h2)
    else $error("multicast outside udp");
  a_ack_tcp: assert property (sockImmediateAck[0] |-> $past(sockProtocol[3:0]) == 4'h1)
    else $error("ack option outside tcp");
  a_filter_raw: assert property (sockFrameFilterEn[0] |-> $past(sockProtocol[3:0]) == 4'h4)
    else $error("filter outside raw frame");
  a_igmp_multi: assert property ((sockIgmpV1 & ~sockMulticastEn) == 8'h00)
    else $error("igmp flag without multicast");
  cover property (sockOpenPulse[0]);
  cover property (sockMulticastEn[1]);
  cover property (sockFrameFilterEn[0]);
endmodule
bind smc_socket_mode_config smc_socket_mode_config_assertions i_chk (.*);
`default_nettype wire

//--- test/testbench.sv
// self-checking bench for the socket mode bank
`default_nettype none
module testbench import smc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst_n = 0, regWrEn = 0, regRdEn = 0, regHit;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0] regWrData = 8'h00, regRdData, sockOpenPulse, sockMulticastEn;
  logic [7:0] sockFrameFilterEn, sockImmediateAck, sockIgmpV1;
  logic [SMC_NUM_SOCK*4-1:0] sockProtocol;
  int error_cnt = 0, tests_run = 0;
  always #2.5 mclk = ~mclk;
  smc_socket_mode_config i_smc_socket_mode_config (.*);
  task automatic cmp(input logic [7:0] g, e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %0t %h %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic w);
    @(negedge mclk);
    regAddr = a;
    regWrData = d;
    regWrEn = w;
    regRdEn = !w;
    @(negedge mclk);
    regWrEn = 0;
    regRdEn = 0;
  endtask
  // codes 4 and 5 only open on socket 0
  function automatic logic [3:0] eproto(input int s, input logic [3:0] p);
    return (p < 4 || (s == 0 && p < 6)) ? p : 4'h0;
  endfunction
  task automatic close_out(input int hung);
    error_cnt += hung;
    $display("errors %0d compares %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial #50us close_out(1);
  initial begin
    logic [15:0] a;
    logic [7:0] m;
    logic [3:0] ep;
    logic [7:0] ef;
    int s;
    void'($urandom(30));
    repeat (20) @(negedge mclk);
    rst_n = 1;
    // index 8 lands past the last socket
    for (int i = 0; i < 9; i++) begin
      acc(16'h4000 + 16'(i) * 16'h0100, 8'h00, 0);
      cmp(regRdData, 8'h00);
      cmp(8'(regHit), 8'(i < 8));
    end
    for (int i = 0; i < 128; i++) begin
      s = i / 16;
      a = 16'h4000 + 16'(s) * 16'h0100;
      // passes with index bit 3 set (8 to 15 of every sixteen) force all options on, filter included
      m = {i[3] ? 3'b111 : 3'($urandom()), 1'b1, 4'(i % 8)};
      acc(a, m, 1);
      acc(a, 8'h00, 0);
      cmp(regRdData, m & 8'hEF);
      acc(a + 16'h0001, 8'h01, 1);
      cmp(8'(sockOpenPulse[s]), 8'h01);
      @(negedge mclk);
      ep = eproto(s, m[3:0]);
      cmp(8'(sockProtocol[s*4+:4]), 8'(ep));
      ef = 8'({m[7] && ep == 2, m[6] && ep == 4, m[5] && ep == 1, m[7] && m[5] && ep == 2});
      cmp(8'({sockMulticastEn[s], sockFrameFilterEn[s], sockImmediateAck[s], sockIgmpV1[s]}), ef);
      acc(a + 16'h0001, 8'h00, 0);
      cmp(regRdData, 8'h00);
    end
    // reset in mid-run clears the bank again
    @(negedge mclk);
    rst_n = 0;
    repeat (2) @(negedge mclk);
    rst_n = 1;
    cmp(8'(sockProtocol[3:0]), 8'h00);
    acc(16'h4000, 8'h00, 0);
    cmp(regRdData, 8'h00);
    close_out(0);
  end
endmodule
`default_nettype wire
